// file: rtl/rcd_pkg.sv
// Constants shared by the reset and default clock controller
package rcd_pkg;

	// ==================================================================
	// System clock
	localparam int CLK_PERIOD_PS = 8000;   // 125 MHz

	// ==================================================================
	// Internal oscillator figures
	localparam int FAST_OSC_KHZ  = 16000;
	localparam int SLOW_OSC_KHZ  = 128;
	localparam int CORE_DIV      = 8;
	localparam int CORE_KHZ      = FAST_OSC_KHZ / CORE_DIV;
	localparam int DIV_HALF      = CORE_DIV / 4;    // Counted on rising edges only
	localparam int DIV_W         = 2;

	// ==================================================================
	// Reset pin timing, in picoseconds
	localparam int FILT_MIN_PS   = 75000;
	localparam int VALID_MAX_PS  = 450000;
	localparam int INT_PULSE_PS  = 30000;
	localparam int REQ_MIN_PS    = 20000;
	localparam int STRETCH_PS    = 20000000;

	// Derived cycle counts: least times round up, longest times round down
	localparam int FILT_CYC      = (FILT_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int VALID_CYC     = VALID_MAX_PS / CLK_PERIOD_PS;
	localparam int INT_PULSE_CYC = (INT_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int REQ_MIN_CYC   = (REQ_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int STRETCH_CYC   = (STRETCH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int GUARD_CYC     = 8;      // Pull-up settle before the pin is trusted again

	localparam int FILT_W        = 4;
	localparam int PULSE_W       = 3;
	localparam int STRETCH_W     = 12;
	localparam int GUARD_W       = 4;

	// ==================================================================
	// Reset cause bit positions
	localparam int CAUSE_PIN     = 0;
	localparam int CAUSE_POR     = 1;
	localparam int CAUSE_BROWN   = 2;
	localparam int CAUSE_INDEPENDENT_WATCHDOG    = 3;
	localparam int CAUSE_WINDOW_WATCHDOG    = 4;
	localparam int CAUSE_SW      = 5;
	localparam int CAUSE_DEBUG   = 6;
	localparam int CAUSE_OPCODE  = 7;
	localparam int CAUSE_CORRUPT = 8;
	localparam int NUM_CAUSE     = 9;
	localparam logic [NUM_CAUSE-1:0] CAUSE_RESET = 9'h000;

	// ==================================================================
	// Clock source selection
	typedef enum logic [1:0] {
		SRC_FAST_DIV8 = 2'b00,
		SRC_FAST      = 2'b01,
		SRC_SLOW      = 2'b10,
		SRC_EXTERNAL  = 2'b11
	} rcd_clk_src_t;

	// Reset pin stretcher states
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_STRETCH = 2'b01,
		ST_GUARD   = 2'b10
	} rcd_state_t;

endpackage

// file: rtl/rcd_reset_clock_ctrl.sv
// Reset source collector, reset pin filter and stretcher, default core clock
`timescale 1ns/1ps
module rcd_reset_clock_ctrl (
	input  wire logic                          SYS_CLK_I,
	input  wire logic                          RST_I,
	// Reset pin, open drain
	input  wire logic                          RESET_PIN_N_I,
	output logic                               RESET_PIN_N_O,
	output logic                               RESET_PIN_N_OE_N_O,
	// Reset sources
	input  wire logic                          POWER_NOT_OK_I,
	input  wire logic                          BROWNOUT_RESET_I,
	input  wire logic                          INDEPENDENT_WATCHDOG_I,
	input  wire logic                          WINDOW_WATCHDOG_I,
	input  wire logic                          SW_RESET_REQ_I,
	input  wire logic                          DEBUG_RESET_REQ_I,
	input  wire logic                          ILLEGAL_OPCODE_I,
	input  wire logic                          REGISTER_CORRUPTION_RESET_I,
	// Reset results
	output logic                               CORE_RST_O,
	output logic [rcd_pkg::NUM_CAUSE-1:0]      RST_CAUSE_O,
	input  wire logic [rcd_pkg::NUM_CAUSE-1:0] CAUSE_CLR_I,
	// Oscillators and clock selection
	input  wire logic                          FAST_INTERNAL_OSC_I,
	input  wire logic                          SLOW_INTERNAL_OSC_I,
	input  wire logic [1:0]                    CLK_SEL_I,
	input  wire logic                          CLK_SEL_WR_I,
	input  wire logic                          CRYSTAL_MODE_I,
	output logic [1:0]                         CLK_SRC_O,
	output logic                               CORE_CLK_O,
	output logic                               CLOCK_OUTPUT_PIN_O,
	// Oscillator pins, two-way
	input  wire logic                          OSC_INPUT_PIN_I,
	output logic                               OSC_INPUT_PIN_O,
	output logic                               OSC_INPUT_PIN_OE_N_O,
	input  wire logic                          OSC_OUTPUT_PIN_I,
	output logic                               OSC_OUTPUT_PIN_O,
	output logic                               OSC_OUTPUT_PIN_OE_N_O,
	// GPIO use of the oscillator pins
	input  wire logic [1:0]                    GPIO_OUT_I,
	input  wire logic [1:0]                    GPIO_DRIVE_I,
	output logic [1:0]                         GPIO_IN_O
);

	// ==================================================================
	// Synchronisers
	// Everything arriving from pins or analog blocks passes two flops
	localparam int NSYNC = 7;
	logic [NSYNC-1:0] async_in;
	logic [NSYNC-1:0] sync1_ff;
	logic [NSYNC-1:0] sync2_ff;
	logic             pin_n_s;
	logic             por_s;
	logic             brown_s;
	logic             fast_s;
	logic             slow_s;
	logic             osc_input_pin_s;
	logic             osc_output_pin_s;

	assign async_in = {OSC_OUTPUT_PIN_I, OSC_INPUT_PIN_I, SLOW_INTERNAL_OSC_I, FAST_INTERNAL_OSC_I,
		BROWNOUT_RESET_I, POWER_NOT_OK_I, RESET_PIN_N_I};

	// One two-flop chain per input bit
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge SYS_CLK_I) begin
				if (RST_I) begin
					sync1_ff[gi] <= (gi == 0) ? 1'b1 : 1'b0;
					sync2_ff[gi] <= (gi == 0) ? 1'b1 : 1'b0;
				end else begin
					sync1_ff[gi] <= async_in[gi];
					sync2_ff[gi] <= sync1_ff[gi];
				end
			end
		end
	endgenerate

	assign pin_n_s  = sync2_ff[0];
	assign por_s    = sync2_ff[1];
	assign brown_s  = sync2_ff[2];
	assign fast_s   = sync2_ff[3];
	assign slow_s   = sync2_ff[4];
	assign osc_input_pin_s  = sync2_ff[5];
	assign osc_output_pin_s = sync2_ff[6];

	// ==================================================================
	// Reset pin glitch filter
	// Any high sample restarts the count, so spike trains never add up
	logic [rcd_pkg::FILT_W-1:0] low_cnt_ff;
	logic                       low_seen_ff;
	logic                       pin_watch;
	logic                       pin_valid;
	rcd_pkg::rcd_state_t        state_ff;

	// Our own drive is masked so the stretcher cannot retrigger itself
	assign pin_watch = (state_ff == rcd_pkg::ST_IDLE);
	assign pin_valid = pin_watch && !pin_n_s && !low_seen_ff &&
		(low_cnt_ff == rcd_pkg::FILT_W'(rcd_pkg::FILT_CYC));

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			low_cnt_ff <= '0;
		end else if (!pin_watch || pin_n_s) begin
			low_cnt_ff <= '0;
		end else if (low_cnt_ff != rcd_pkg::FILT_W'(rcd_pkg::FILT_CYC)) begin
			low_cnt_ff <= low_cnt_ff + rcd_pkg::FILT_W'(1);
		end
	end

	// One accepted event per low level while in ST_IDLE; a low still held after stretch and guard is accepted again
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			low_seen_ff <= 1'b0;
		end else if (!pin_watch || pin_n_s) begin
			low_seen_ff <= 1'b0;
		end else if (pin_valid) begin
			low_seen_ff <= 1'b1;
		end
	end

	// ==================================================================
	// Internal pulse from a valid pin event
	logic [rcd_pkg::PULSE_W-1:0] pulse_cnt_ff;
	logic                        pin_rst;

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			pulse_cnt_ff <= '0;
		end else if (pin_valid) begin
			pulse_cnt_ff <= rcd_pkg::PULSE_W'(rcd_pkg::INT_PULSE_CYC);
		end else if (pulse_cnt_ff != '0) begin
			pulse_cnt_ff <= pulse_cnt_ff - rcd_pkg::PULSE_W'(1);
		end
	end

	assign pin_rst = (pulse_cnt_ff != '0);

	// ==================================================================
	// Source merge
	logic [rcd_pkg::NUM_CAUSE-1:0] src_vec;
	logic                          any_req;

	always_comb begin
		src_vec                         = '0;
		src_vec[rcd_pkg::CAUSE_PIN]     = pin_rst;
		src_vec[rcd_pkg::CAUSE_POR]     = por_s;
		src_vec[rcd_pkg::CAUSE_BROWN]   = brown_s;
		src_vec[rcd_pkg::CAUSE_INDEPENDENT_WATCHDOG]    = INDEPENDENT_WATCHDOG_I;
		src_vec[rcd_pkg::CAUSE_WINDOW_WATCHDOG]    = WINDOW_WATCHDOG_I;
		src_vec[rcd_pkg::CAUSE_SW]      = SW_RESET_REQ_I;
		src_vec[rcd_pkg::CAUSE_DEBUG]   = DEBUG_RESET_REQ_I;
		src_vec[rcd_pkg::CAUSE_OPCODE]  = ILLEGAL_OPCODE_I;
		src_vec[rcd_pkg::CAUSE_CORRUPT] = REGISTER_CORRUPTION_RESET_I;
	end

	assign any_req = |src_vec;

	// ==================================================================
	// Reset cause flags
	// Kept through core resets so software can read why it restarted
	logic [rcd_pkg::NUM_CAUSE-1:0] cause_ff;

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			cause_ff <= rcd_pkg::CAUSE_RESET;
		end else begin
			cause_ff <= (cause_ff & ~CAUSE_CLR_I) | src_vec; // Set wins over clear
		end
	end

	assign RST_CAUSE_O = cause_ff;

	// ==================================================================
	// Reset pin stretcher
	// Counting restarts from the request's fall, so a long request extends the pin low
	logic [rcd_pkg::STRETCH_W-1:0] stretch_cnt_ff;
	logic [rcd_pkg::GUARD_W-1:0]   guard_cnt_ff;

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			state_ff <= rcd_pkg::ST_STRETCH;
		end else begin
			case (state_ff)
				rcd_pkg::ST_IDLE: begin
					if (any_req) begin
						state_ff <= rcd_pkg::ST_STRETCH;
					end
				end
				rcd_pkg::ST_STRETCH: begin
					if (!any_req && stretch_cnt_ff == '0) begin
						state_ff <= rcd_pkg::ST_GUARD;
					end
				end
				rcd_pkg::ST_GUARD: begin
					if (any_req) begin
						state_ff <= rcd_pkg::ST_STRETCH;
					end else if (guard_cnt_ff == '0) begin
						state_ff <= rcd_pkg::ST_IDLE;
					end
				end
				default: begin
					state_ff <= rcd_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Stretch counter reloads while any request stands
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I || any_req) begin
			stretch_cnt_ff <= rcd_pkg::STRETCH_W'(rcd_pkg::STRETCH_CYC - 1);
		end else if (state_ff == rcd_pkg::ST_STRETCH && stretch_cnt_ff != '0) begin
			stretch_cnt_ff <= stretch_cnt_ff - rcd_pkg::STRETCH_W'(1);
		end
	end

	// Guard lets the external pull-up lift the pin before watching it
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I || state_ff != rcd_pkg::ST_GUARD) begin
			guard_cnt_ff <= rcd_pkg::GUARD_W'(rcd_pkg::GUARD_CYC - 1);
		end else if (guard_cnt_ff != '0) begin
			guard_cnt_ff <= guard_cnt_ff - rcd_pkg::GUARD_W'(1);
		end
	end

	// Open drain: only ever pulls low
	assign RESET_PIN_N_O      = 1'b0;
	assign RESET_PIN_N_OE_N_O = (state_ff != rcd_pkg::ST_STRETCH);

	// ==================================================================
	// Core reset
	// Held across the whole stretch, released one cycle after the pin
	logic core_rst_ff;

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			core_rst_ff <= 1'b1;
		end else begin
			core_rst_ff <= any_req || (state_ff == rcd_pkg::ST_STRETCH);
		end
	end

	assign CORE_RST_O = core_rst_ff;

	// ==================================================================
	// Fast oscillator divider
	// The sampled oscillator is only 16 MHz, so its edges are seen reliably at 125 MHz
	logic                     fast_d_ff;
	logic                     fast_rise;
	logic [rcd_pkg::DIV_W-1:0] div_cnt_ff;
	logic                     div_clk_ff;

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			fast_d_ff <= 1'b0;
		end else begin
			fast_d_ff <= fast_s;
		end
	end

	assign fast_rise = fast_s && !fast_d_ff;

	// Toggle every CORE_DIV/2 rising edges gives fast divided by CORE_DIV
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			div_cnt_ff <= '0;
			div_clk_ff <= 1'b0;
		end else if (fast_rise) begin
			if (div_cnt_ff == rcd_pkg::DIV_W'(rcd_pkg::DIV_HALF * 2 - 1)) begin
				div_cnt_ff <= '0;
				div_clk_ff <= !div_clk_ff;
			end else begin
				div_cnt_ff <= div_cnt_ff + rcd_pkg::DIV_W'(1);
			end
		end
	end

	// ==================================================================
	// Clock source selection
	// Any core reset returns to the default source
	rcd_pkg::rcd_clk_src_t clk_sel_ff;

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I || core_rst_ff) begin
			clk_sel_ff <= rcd_pkg::SRC_FAST_DIV8;
		end else if (CLK_SEL_WR_I) begin
			clk_sel_ff <= rcd_pkg::rcd_clk_src_t'(CLK_SEL_I);
		end
	end

	assign CLK_SRC_O = clk_sel_ff;

	// Selected source, registered before it leaves the block
	logic core_clk_ff;
	logic nxt_core_clk;

	always_comb begin
		case (clk_sel_ff)
			rcd_pkg::SRC_FAST:     nxt_core_clk = fast_s;
			rcd_pkg::SRC_SLOW:     nxt_core_clk = slow_s;
			rcd_pkg::SRC_EXTERNAL: nxt_core_clk = osc_input_pin_s;
			default:               nxt_core_clk = div_clk_ff;
		endcase
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			core_clk_ff <= 1'b0;
		end else begin
			core_clk_ff <= nxt_core_clk;
		end
	end

	assign CORE_CLK_O         = core_clk_ff;
	assign CLOCK_OUTPUT_PIN_O = core_clk_ff;

	// ==================================================================
	// Oscillator pins
	// In crystal mode the output pin drives the inverted input as the amplifier
	logic ext_used;
	logic osc_drv_ff;

	assign ext_used = (clk_sel_ff == rcd_pkg::SRC_EXTERNAL);

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			osc_drv_ff <= 1'b1;
		end else begin
			osc_drv_ff <= !osc_input_pin_s;
		end
	end

	// Without an external source both pins belong to GPIO
	always_comb begin
		if (ext_used) begin
			OSC_INPUT_PIN_O       = 1'b0;
			OSC_INPUT_PIN_OE_N_O  = 1'b1;
			OSC_OUTPUT_PIN_O      = osc_drv_ff;
			OSC_OUTPUT_PIN_OE_N_O = !CRYSTAL_MODE_I;
		end else begin
			OSC_INPUT_PIN_O       = GPIO_OUT_I[0];
			OSC_INPUT_PIN_OE_N_O  = !GPIO_DRIVE_I[0];
			OSC_OUTPUT_PIN_O      = GPIO_OUT_I[1];
			OSC_OUTPUT_PIN_OE_N_O = !GPIO_DRIVE_I[1];
		end
	end

	// Pin levels read back; valid whatever the mode
	assign GPIO_IN_O = {osc_output_pin_s, osc_input_pin_s};

endmodule

// file: verification/rcd_reset_clock_ctrl_assertions.sv
// Port-level assertions for the reset and default clock controller
`timescale 1ns/1ps
module rcd_reset_clock_ctrl_chk (
	input wire logic                          SYS_CLK_I,
	input wire logic                          RST_I,
	input wire logic                          RESET_PIN_N_I,
	input wire logic                          RESET_PIN_N_O,
	input wire logic                          RESET_PIN_N_OE_N_O,
	input wire logic                          POWER_NOT_OK_I,
	input wire logic                          INDEPENDENT_WATCHDOG_I,
	input wire logic                          WINDOW_WATCHDOG_I,
	input wire logic                          SW_RESET_REQ_I,
	input wire logic                          DEBUG_RESET_REQ_I,
	input wire logic                          ILLEGAL_OPCODE_I,
	input wire logic                          REGISTER_CORRUPTION_RESET_I,
	input wire logic                          CORE_RST_O,
	input wire logic [rcd_pkg::NUM_CAUSE-1:0] RST_CAUSE_O,
	input wire logic [1:0]                    CLK_SRC_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (RST_I);
	// ==========================================
	// Helper counters
	logic [11:0] low_cnt_ff;   // Cycles the pin has been pulled by us
	logic [4:0]  run_ff;       // Cycles of one unbroken pin low seen while the device idles
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I || RESET_PIN_N_OE_N_O)
			low_cnt_ff <= 12'h000;
		else if (low_cnt_ff != 12'hfff)
			low_cnt_ff <= low_cnt_ff + 12'h001;
	end
	// Idle pin watch; guard cycles plus filter must fit well under 450 ns
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I || RESET_PIN_N_I || !RESET_PIN_N_OE_N_O || CORE_RST_O)
			run_ff <= 5'h00;
		else if (run_ff != 5'h1f)
			run_ff <= run_ff + 5'h01;
	end
	// ==========================================
	// Assertions
	chk_sw_reset: assert property (SW_RESET_REQ_I |=> CORE_RST_O && RST_CAUSE_O[rcd_pkg::CAUSE_SW])
		else $error("software request lost");
	chk_debug_cause: assert property (DEBUG_RESET_REQ_I |=> RST_CAUSE_O[rcd_pkg::CAUSE_DEBUG])
		else $error("debug request lost");
	chk_opcode_cause: assert property (ILLEGAL_OPCODE_I |=> RST_CAUSE_O[rcd_pkg::CAUSE_OPCODE])
		else $error("opcode reset lost");
	chk_corrupt_cause: assert property (REGISTER_CORRUPTION_RESET_I |=> RST_CAUSE_O[rcd_pkg::CAUSE_CORRUPT])
		else $error("corruption reset lost");
	chk_wdg_pin: assert property (INDEPENDENT_WATCHDOG_I || WINDOW_WATCHDOG_I |=> !RESET_PIN_N_OE_N_O)
		else $error("watchdog did not pull pin");
	chk_core_covers: assert property (!RESET_PIN_N_OE_N_O |-> CORE_RST_O)
		else $error("pin low without core reset");
	chk_stretch_len: assert property (RESET_PIN_N_OE_N_O && low_cnt_ff != 12'h000 |->
		low_cnt_ff >= rcd_pkg::STRETCH_CYC)
		else $error("pin released too early");
	chk_power_hold: assert property (POWER_NOT_OK_I [*4] |=> CORE_RST_O)
		else $error("core ran on low supply");
	chk_pin_valid: assert property (run_ff < 5'h1c)
		else $error("long pin low not taken");
	chk_clk_default: assert property ($fell(CORE_RST_O) |-> CLK_SRC_O == 2'h0)
		else $error("clock source not default");
	chk_pin_drive: assert property (RESET_PIN_N_O == 1'b0)
		else $error("pin driven high");
	// Main scenarios
	cov_sw: cover property (SW_RESET_REQ_I);
	cov_release: cover property ($rose(RESET_PIN_N_OE_N_O));
	cov_short: cover property (run_ff == 5'h09);
endmodule
bind rcd_reset_clock_ctrl rcd_reset_clock_ctrl_chk i_rcd_chk (.*);

// file: verification/rcd_reset_button.sv
// Push button and debug host on the far side of the reset controller
`timescale 1ns/1ps
module rcd_reset_button (
	input  wire logic clk_i,
	input  wire logic press_i,
	input  wire logic oe_n_i,
	input  wire logic dbg_cmd_i,
	output logic      pin_n_o,
	output logic      dbg_req_o
);
	// Open-drain wire: either party pulls low, the pull-up wins otherwise
	assign pin_n_o = ~(press_i | ~oe_n_i);
	// Host answers a cycle late, as a real probe would
	always @(posedge clk_i) begin
		dbg_req_o <= dbg_cmd_i;
	end
endmodule

// file: verification/rcd_reset_clock_ctrl_bench.sv
// Self-checking bench of the reset and default clock controller
`timescale 1ns/1ps
module rcd_reset_clock_ctrl_bench;
	logic       SYS_CLK_I = 1'b0;
	logic       RST_I = 1'b1;
	logic [8:0] src = 9'h002;  // Source requests, bit order as cause flags
	logic [8:0] CAUSE_CLR_I = 9'h000;
	logic [1:0] CLK_SEL_I = 2'h0, GPIO_OUT_I = 2'h0, GPIO_DRIVE_I = 2'h0, ext_lvl = 2'h3, sel;
	logic       CLK_SEL_WR_I = 1'b0, CRYSTAL_MODE_I = 1'b0, w;
	logic [8:0] osc_cnt = 9'h000, osc_old;
	logic [8:0] RST_CAUSE_O;
	logic [1:0] CLK_SRC_O, GPIO_IN_O;
	logic       RESET_PIN_N_I, RESET_PIN_N_O, RESET_PIN_N_OE_N_O, CORE_RST_O, CORE_CLK_O, CLOCK_OUTPUT_PIN_O;
	logic       OSC_INPUT_PIN_O, OSC_INPUT_PIN_OE_N_O, OSC_OUTPUT_PIN_O, OSC_OUTPUT_PIN_OE_N_O, DEBUG_RESET_REQ_I;
	int         error_cnt = 0, cmp_count = 0, exp_cause = 0, low_run = 0, n;
	wire POWER_NOT_OK_I = src[1];
	wire BROWNOUT_RESET_I = src[2];
	wire INDEPENDENT_WATCHDOG_I = src[3];
	wire WINDOW_WATCHDOG_I = src[4];
	wire SW_RESET_REQ_I = src[5];
	wire ILLEGAL_OPCODE_I = src[7];
	wire REGISTER_CORRUPTION_RESET_I = src[8];
	wire FAST_INTERNAL_OSC_I = osc_cnt[2];
	wire SLOW_INTERNAL_OSC_I = osc_cnt[8];
	// Oscillator pin wires: ours unless the device drives
	wire OSC_INPUT_PIN_I = OSC_INPUT_PIN_OE_N_O ? ext_lvl[0] : OSC_INPUT_PIN_O;
	wire OSC_OUTPUT_PIN_I = OSC_OUTPUT_PIN_OE_N_O ? ext_lvl[1] : OSC_OUTPUT_PIN_O;
	rcd_reset_clock_ctrl i_rcd_reset_clock_ctrl (.*);
	rcd_reset_button i_rcd_reset_button (.clk_i(SYS_CLK_I), .press_i(src[0]), .oe_n_i(RESET_PIN_N_OE_N_O),
		.dbg_cmd_i(src[6]), .pin_n_o(RESET_PIN_N_I), .dbg_req_o(DEBUG_RESET_REQ_I));
	// ==========================================
	// Clock, oscillators and pulled-low time of the pin
	initial forever #4 SYS_CLK_I = ~SYS_CLK_I;
	always @(posedge SYS_CLK_I) begin
		osc_cnt <= osc_cnt + 9'h001;
		low_run <= RESET_PIN_N_OE_N_O ? 0 : low_run + 1;
	end
	// ==========================================
	// Checking and closing
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Wait out a stretch and its guard; bounded against a stuck pin
	task automatic settle();
		for (n = 0; n < 3000 && CORE_RST_O !== 1'b0; n++) @(negedge SYS_CLK_I);
		repeat (12) @(negedge SYS_CLK_I);
	endtask
	// Raise one source, follow the stretch, then clear flags at random
	task automatic fire(input int idx);
		logic [8:0] m;
		@(posedge SYS_CLK_I) src[idx] <= 1'b1;
		repeat (idx == 0 ? 60 : (idx < 3 ? 6 : 1)) @(posedge SYS_CLK_I);
		src[idx] <= 1'b0;
		for (n = 0; n < 20 && CORE_RST_O !== 1'b1; n++) @(negedge SYS_CLK_I);
		exp_cause = exp_cause | (1 << idx);
		check(CORE_RST_O, 1'b1);
		check(RESET_PIN_N_I, 1'b0);
		check(RST_CAUSE_O, exp_cause[8:0]);
		for (n = 0; n < 3000 && RESET_PIN_N_OE_N_O !== 1'b1; n++) @(negedge SYS_CLK_I);
		check(low_run >= rcd_pkg::STRETCH_CYC, 1'b1);
		settle();
		check(CLK_SRC_O, 2'h0);
		m = 9'($urandom);
		@(posedge SYS_CLK_I) CAUSE_CLR_I <= m;
		@(posedge SYS_CLK_I) CAUSE_CLR_I <= 9'h000;
		exp_cause = exp_cause & ~int'(m);
		@(negedge SYS_CLK_I) check(RST_CAUSE_O, exp_cause[8:0]);
	endtask
	// ==========================================
	// Watchdog
	initial begin
		repeat (60000) @(posedge SYS_CLK_I);
		error_cnt++;
		final_report();
	end
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(24972));
		repeat (20) @(posedge SYS_CLK_I);
		RST_I <= 1'b0;
		// Low supply keeps the core in reset
		repeat (40) @(negedge SYS_CLK_I);
		check(CORE_RST_O, 1'b1);
		@(posedge SYS_CLK_I) src[1] <= 1'b0;
		exp_cause = 2;
		settle();
		check(RST_CAUSE_O, exp_cause[8:0]);
		// Core clock half period: four fast edges of an 8-cycle oscillator
		w = CORE_CLK_O;
		for (n = 0; n < 100 && CORE_CLK_O === w; n++) @(negedge SYS_CLK_I);
		w = CORE_CLK_O;
		for (n = 0; n < 100 && CORE_CLK_O === w; n++) @(negedge SYS_CLK_I);
		check(n, rcd_pkg::CORE_DIV * 4);
		for (int i = 0; i < rcd_pkg::NUM_CAUSE; i++) begin
			// Oscillator pins as GPIO under the default source
			@(posedge SYS_CLK_I);
			GPIO_OUT_I <= 2'($urandom);
			GPIO_DRIVE_I <= 2'($urandom);
			ext_lvl <= 2'($urandom);
			repeat (4) @(negedge SYS_CLK_I);
			check({OSC_OUTPUT_PIN_OE_N_O, OSC_INPUT_PIN_OE_N_O}, 2'(~GPIO_DRIVE_I));
			check({OSC_OUTPUT_PIN_O, OSC_INPUT_PIN_O} & GPIO_DRIVE_I, GPIO_OUT_I & GPIO_DRIVE_I);
			check(GPIO_IN_O, {OSC_OUTPUT_PIN_I, OSC_INPUT_PIN_I});
			// Move off the default source, then reset from source i
			sel = 2'($urandom_range(3, 1));
			@(posedge SYS_CLK_I);
			CLK_SEL_I <= sel;
			CLK_SEL_WR_I <= 1'b1;
			CRYSTAL_MODE_I <= 1'($urandom);
			@(posedge SYS_CLK_I) CLK_SEL_WR_I <= 1'b0;
			repeat (3) @(negedge SYS_CLK_I);
			check(CLK_SRC_O, sel);
			// External source takes the input pin; crystal mode also drives the output pin
			check({OSC_OUTPUT_PIN_OE_N_O, OSC_INPUT_PIN_OE_N_O},
				sel == 2'h3 ? {~CRYSTAL_MODE_I, 1'b1} : 2'(~GPIO_DRIVE_I));
			// Clock pin lags its source by two sync flops and the output flop
			repeat (8) begin
				@(negedge SYS_CLK_I);
				osc_old = osc_cnt - 9'h003;
				check(CLOCK_OUTPUT_PIN_O, sel == 2'h1 ? osc_old[2] : (sel == 2'h2 ? osc_old[8] : ext_lvl[0]));
			end
			fire(i);
		end
		// Short lows, then spike trains with one-cycle gaps, all ignored
		for (int k = 0; k < 16; k++) begin
			@(posedge SYS_CLK_I) src[0] <= 1'b1;
			repeat (k < 8 ? $urandom_range(9, 1) : 9) @(posedge SYS_CLK_I);
			src[0] <= 1'b0;
			repeat (k < 8 ? 20 : 0) @(posedge SYS_CLK_I);
		end
		repeat (20) @(negedge SYS_CLK_I);
		check(CORE_RST_O, 1'b0);
		check(RST_CAUSE_O, exp_cause[8:0]);
		final_report();
	end
endmodule
